/* hdl/wws_sync.sv */
// two-stage synchroniser for the strobe and clear pins
// assumes pins idle high and are asynchronous to i_core_clk
`timescale 1ns/10ps
`default_nettype none
module wws_sync (
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_strobe,
   input  wire logic i_clear_n,
   wws_sync_if.src   o_sync
);
   import wws_pkg::*;
   logic [1:0] strobe_ff;
   logic [1:0] clear_ff;

   // ==========================================
   // synchronisers, idle high so reset sees no edge
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strobe_ff <= SYNC_IDLE;
         clear_ff  <= SYNC_IDLE;
      end else if (i_ce) begin
         strobe_ff <= {strobe_ff[0], i_strobe};
         clear_ff  <= {clear_ff[0], i_clear_n};
      end
   end

   assign o_sync.strobe  = strobe_ff[1];
   assign o_sync.clear_n = clear_ff[1];
endmodule
`default_nettype wire

/* hdl/wws_top.sv */
// window watchdog and supply supervisor logic
// assumes supply status inputs are asynchronous comparator levels
`timescale 1ns/10ps
`default_nettype none
// Function
// - a falling strobe edge zeroes the watchdog interval timer.
// - supply reset release also zeroes the interval timer.
// - strobe edges inside the window keep fault high and restart.
// - edges closer than fast limit give a 50 ms fault pulse.
// - interval beyond slow limit gives a 100 ms fault pulse.
// - reset held low while supply out of window, then hold time.
// - overvoltage sets a sticky latch driving surge output low.
// - clear pulse clears latch only once overvoltage is gone.
// - clear pulse of at least 0.4 us, needs no overvoltage, reset high.
// - clear low longer than 5 us asserts supply reset.
// - clear input ignored while overvoltage is present.
module wws_top #(
   parameter int unsigned FAST_WIN  = wws_pkg::FAST_WIN_CYC,
   parameter int unsigned SLOW_WIN  = wws_pkg::SLOW_WIN_CYC,
   parameter int unsigned HOLD      = wws_pkg::HOLD_CYC,
   parameter int unsigned FAULT_FST = wws_pkg::FAULT_FAST_CYC,
   parameter int unsigned FAULT_SLW = wws_pkg::FAULT_SLOW_CYC
) (
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   input  wire logic i_ce,
   input  wire logic i_watchdog_strobe,
   input  wire logic i_fault_clear_n,
   input  wire logic i_supply_in_window,
   input  wire logic i_supply_over,
   output logic      o_watchdog_fault_n,
   output logic      o_watchdog_fault_oe,
   output logic      o_supply_reset_n,
   output logic      o_supply_reset_oe,
   output logic      o_surge_latch_n,
   output logic      o_surge_latch_oe
);
   import wws_pkg::*;

   // ==========================================
   // limits at counter width
   // all limits count core clock cycles, so one clock times everything
   localparam logic [CNT_W-1:0] FAST_LIM  = CNT_W'(FAST_WIN);
   localparam logic [CNT_W-1:0] SLOW_LIM  = CNT_W'(SLOW_WIN);
   localparam logic [CNT_W-1:0] HOLD_LIM  = CNT_W'(HOLD) - CNT_ONE;
   localparam logic [CNT_W-1:0] FST_LOAD  = CNT_W'(FAULT_FST) - CNT_ONE;
   localparam logic [CNT_W-1:0] SLW_LOAD  = CNT_W'(FAULT_SLW) - CNT_ONE;
   localparam logic [CLR_W-1:0] CLR_MIN   = CLR_W'(CLEAR_MIN_CYC);
   localparam logic [CLR_W-1:0] CLR_RESET = CLR_W'(CLEAR_RESET_CYC);

   // ==========================================
   // reset release
   logic [1:0] rst_ff;
   logic       rst_n;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) rst_ff <= 2'h0;
      else         rst_ff <= {rst_ff[0], 1'h1};
   end
   assign rst_n = rst_ff[1];

   // ==========================================
   // pin synchronisers
   wws_sync_if sync_bus ();
   wws_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (rst_n),
      .i_ce       (i_ce),
      .i_strobe   (i_watchdog_strobe),
      .i_clear_n  (i_fault_clear_n),
      .o_sync     (sync_bus.src)
   );

   // supply status from comparators: two flops each
   logic [1:0] win_ff;
   logic [1:0] ov_ff;
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         win_ff <= 2'h0;
         ov_ff  <= 2'h0;
      end else if (i_ce) begin
         win_ff <= {win_ff[0], i_supply_in_window};
         ov_ff  <= {ov_ff[0], i_supply_over};
      end
   end
   logic in_win;
   logic over;
   assign in_win = win_ff[1];
   assign over   = ov_ff[1];

   // ==========================================
   // strobe edge detect
   logic strobe_q;
   logic strobe_fall;
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n)    strobe_q <= 1'h1;
      else if (i_ce) strobe_q <= sync_bus.strobe;
   end
   assign strobe_fall = strobe_q & ~sync_bus.strobe;

   // ==========================================
   // clear pin low-time measurement
   logic [CLR_W-1:0] clr_cnt;
   logic             clr_long;
   logic             clr_low;
   assign clr_low = ~sync_bus.clear_n & ~over;
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_cnt <= CLR_ZERO;
      end else if (i_ce) begin
         if (!clr_low)                           clr_cnt <= CLR_ZERO;
         else if (clr_cnt != {CLR_W{1'b1}})      clr_cnt <= clr_cnt + CLR_ONE;
      end
   end
   assign clr_long = (clr_cnt > CLR_RESET);

   // ==========================================
   // supply reset with hold time
   logic [CNT_W-1:0] hold_cnt;
   logic             sup_rst_n;
   logic             sup_rst_q;
   logic             rst_release;
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt  <= CNT_ZERO;
         sup_rst_n <= 1'h0;
      end else if (i_ce) begin
         if (!in_win || clr_long) begin
            hold_cnt  <= CNT_ZERO;
            sup_rst_n <= 1'h0;
         end else if (!sup_rst_n) begin
            if (hold_cnt >= HOLD_LIM) sup_rst_n <= 1'h1;
            else                      hold_cnt  <= hold_cnt + CNT_ONE;
         end
      end
   end
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n)    sup_rst_q <= 1'h0;
      else if (i_ce) sup_rst_q <= sup_rst_n;
   end
   assign rst_release = sup_rst_n & ~sup_rst_q;

   // ==========================================
   // overvoltage latch; set wins over clear
   logic surge;
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         surge <= 1'h0;
      end else if (i_ce) begin
         if (over)                                    surge <= 1'h1;
         else if (clr_cnt == CLR_MIN && sup_rst_n)
            surge <= 1'h0;
      end
   end

   // ==========================================
   // window watchdog
   // the timer saturates so a stuck host does not wrap into a good window
   wws_wd_state_t    wd_state;
   logic [CNT_W-1:0] iv_cnt;
   logic [CNT_W-1:0] pulse_cnt;
   logic             too_fast;
   logic             too_slow;
   assign too_fast = (wd_state == WWS_RUN) && strobe_fall && (iv_cnt < FAST_LIM);
   // slow is judged in arm as well: the timer restarted at release
   assign too_slow = (wd_state != WWS_PULSE) && !strobe_fall && (iv_cnt >= SLOW_LIM);

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         iv_cnt <= CNT_ZERO;
      end else if (i_ce) begin
         if (strobe_fall || rst_release || !sup_rst_n) iv_cnt <= CNT_ZERO;
         else if (iv_cnt != {CNT_W{1'b1}})              iv_cnt <= iv_cnt + CNT_ONE;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_state  <= WWS_ARM;
         pulse_cnt <= CNT_ZERO;
      end else if (i_ce) begin
         case (wd_state)
            WWS_ARM: begin
               // first edge after reset opens the window; it has no partner edge,
               // so it is never judged fast
               if (too_slow) begin
                  wd_state  <= WWS_PULSE;
                  pulse_cnt <= SLW_LOAD;
               end else if (sup_rst_n && strobe_fall) begin
                  wd_state <= WWS_RUN;
               end
            end
            WWS_RUN: begin
               if (!sup_rst_n) begin
                  wd_state <= WWS_ARM;
               end else if (too_fast) begin
                  wd_state  <= WWS_PULSE;
                  pulse_cnt <= FST_LOAD;
               end else if (too_slow) begin
                  wd_state  <= WWS_PULSE;
                  pulse_cnt <= SLW_LOAD;
               end
            end
            WWS_PULSE: begin
               if (pulse_cnt == CNT_ZERO) wd_state <= WWS_RUN;
               else                       pulse_cnt <= pulse_cnt - CNT_ONE;
            end
            default: wd_state <= WWS_ARM;
         endcase
      end
   end

   // ==========================================
   // open-drain outputs: enable high while pulling low
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_watchdog_fault_n <= 1'h1;
         o_supply_reset_n   <= 1'h0;
         o_surge_latch_n    <= 1'h1;
      end else if (i_ce) begin
         o_watchdog_fault_n <= (wd_state != WWS_PULSE);
         o_supply_reset_n   <= sup_rst_n;
         o_surge_latch_n    <= ~surge;
      end
   end
   assign o_watchdog_fault_oe = ~o_watchdog_fault_n;
   assign o_supply_reset_oe   = ~o_supply_reset_n;
   assign o_surge_latch_oe    = ~o_surge_latch_n;
endmodule
`default_nettype wire

/* shared/wws_pkg.sv */
// constants and types shared by the window watchdog supervisor
// assumes a 10 MHz core clock
`default_nettype none
package wws_pkg;
   // ==========================================
   // clock
   localparam int unsigned CLK_HZ = 10_000_000;

   // ==========================================
   // documented times, in their own units
   localparam int unsigned FAULT_FAST_MS   = 50;
   localparam int unsigned FAULT_SLOW_MS   = 100;
   localparam real         CLEAR_MIN_US    = 0.4;
   localparam int unsigned CLEAR_RESET_US  = 5;
   localparam int unsigned FAST_WIN_MS     = 8;
   localparam int unsigned SLOW_WIN_MS     = 80;
   localparam int unsigned HOLD_MS         = 10;

   // ==========================================
   // derived cycle counts
   localparam int unsigned FAULT_FAST_CYC  = FAULT_FAST_MS * (CLK_HZ / 1000);
   localparam int unsigned FAULT_SLOW_CYC  = FAULT_SLOW_MS * (CLK_HZ / 1000);
   localparam int unsigned CLEAR_MIN_CYC   = $rtoi($ceil(CLEAR_MIN_US * CLK_HZ / 1.0e6));
   localparam int unsigned CLEAR_RESET_CYC = CLEAR_RESET_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FAST_WIN_CYC    = FAST_WIN_MS * (CLK_HZ / 1000);
   localparam int unsigned SLOW_WIN_CYC    = SLOW_WIN_MS * (CLK_HZ / 1000);
   localparam int unsigned HOLD_CYC        = HOLD_MS * (CLK_HZ / 1000);

   localparam int unsigned CNT_W   = 32;
   localparam int unsigned CLR_W   = 8;

   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;
   localparam logic [CLR_W-1:0] CLR_ZERO = 8'h00;
   localparam logic [CLR_W-1:0] CLR_ONE  = 8'h01;
   localparam logic [1:0]       SYNC_IDLE = 2'h3;

   typedef enum logic [2:0] {
      WWS_ARM  = 3'b001,
      WWS_RUN  = 3'b010,
      WWS_PULSE = 3'b100
   } wws_wd_state_t;
endpackage
`default_nettype wire

/* shared/wws_sync_if.sv */
// carries synchronised pin levels from the synchroniser to the core
// assumes one clock domain
`timescale 1ns/10ps
`default_nettype none
interface wws_sync_if;
   logic strobe;
   logic clear_n;
   modport src (output strobe, output clear_n);
   modport dst (input  strobe, input  clear_n);
endinterface
`default_nettype wire

/* verif/wws_host.sv */
// strobe source standing in for the host processor
// assumes the core clock runs; strobe idles high
`timescale 1ns/10ps
`default_nettype none
module wws_host (
   input  wire logic        i_core_clk,
   input  wire logic        i_go,
   input  wire logic [15:0] i_gap,
   output logic             o_strobe
);
   int   n = 0;
   logic go_q = 1'h0;
   // controls taken at the rising edge, where the bench holds them still
   always @(posedge i_core_clk) begin
      go_q <= i_go;
      if (!go_q) n <= 0;
      else       n <= (n + 1 >= i_gap) ? 0 : n + 1;
   end
   // low for 4 cycles at the start of every period, moved off the sampling edge
   always @(negedge i_core_clk) begin
      o_strobe <= !go_q || n >= 4;
   end
endmodule
`default_nettype wire

/* verif/wws_top_asserts.sv */
// assertions on the supervisor's top-level pins
// assumes a bind onto wws_top, one clock
`timescale 1ns/10ps
`default_nettype none
module wws_top_asserts #(
   parameter int unsigned FAULT_FST = 50,
   parameter int unsigned FAULT_SLW = 100,
   parameter int unsigned HOLD      = 30
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_fault_clear_n,
   input wire logic i_supply_in_window,
   input wire logic i_supply_over,
   input wire logic o_watchdog_fault_n,
   input wire logic o_supply_reset_n,
   input wire logic o_surge_latch_n
);
   int lo_cnt, win_cnt, clr_cnt;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // =====
   // run-length counters on raw pins
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lo_cnt  <= 0;
         win_cnt <= 0;
         clr_cnt <= 0;
      end else begin
         lo_cnt  <= o_watchdog_fault_n ? 0 : lo_cnt + 1;
         win_cnt <= i_supply_in_window ? win_cnt + 1 : 0;
         clr_cnt <= (i_fault_clear_n || i_supply_over) ? 0 : clr_cnt + 1;
      end
   end
   a_fault_pulse_len:
      assert property ($rose(o_watchdog_fault_n) |-> lo_cnt == FAULT_FST || lo_cnt == FAULT_SLW)
      else $error("fault pulse length wrong");
   a_reset_on_drop:
      assert property ($fell(i_supply_in_window) |-> ##[1:5] !o_supply_reset_n)
      else $error("reset not asserted");
   a_reset_hold:
      assert property ($rose(o_supply_reset_n) |-> win_cnt >= HOLD)
      else $error("reset released early");
   a_surge_set:
      assert property ($rose(i_supply_over) |-> ##[1:5] !o_surge_latch_n)
      else $error("surge flag not set");
   a_surge_sticky:
      assert property ((!o_surge_latch_n && i_fault_clear_n) [*6] |=> !o_surge_latch_n)
      else $error("surge flag dropped");
   a_over_blocks_clear:
      assert property (i_supply_over [*5] |-> !o_surge_latch_n)
      else $error("surge flag clear while over");
   a_clear_when_safe:
      assert property ($rose(o_surge_latch_n) |-> !$past(i_supply_over, 4) && $past(o_supply_reset_n))
      else $error("surge flag cleared wrongly");
   a_long_clear_reset:
      assert property (clr_cnt == 60 |-> !o_supply_reset_n)
      else $error("long clear gave no reset");
endmodule
bind wws_top wws_top_asserts #(.FAULT_FST(FAULT_FST), .FAULT_SLW(FAULT_SLW), .HOLD(HOLD)) chk (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_fault_clear_n(i_fault_clear_n),
   .i_supply_in_window(i_supply_in_window), .i_supply_over(i_supply_over),
   .o_watchdog_fault_n(o_watchdog_fault_n), .o_supply_reset_n(o_supply_reset_n),
   .o_surge_latch_n(o_surge_latch_n));
`default_nettype wire

/* verif/wws_top_bench.sv */
// self-checking bench for the window watchdog supervisor
// assumes wws_host drives the strobe; small cycle counts
`timescale 1ns/10ps
`default_nettype none
module wws_top_bench;
   localparam int FF = 50, FS = 100, HD = 30;
   logic clk = 0, nrst = 0, clr_n = 1, win = 1, ovr = 0, go = 0;
   logic [15:0] gap = 16'h0064;
   logic strb, wdo_n, rst_n, ov_n, wdo_oe, rst_oe, ov_oe;
   int fails = 0, num_checks = 0;
   always #50 clk = ~clk;
   wws_host host (.i_core_clk(clk), .i_go(go), .i_gap(gap), .o_strobe(strb));
   wws_top #(.FAST_WIN(20), .SLOW_WIN(200), .HOLD(HD), .FAULT_FST(FF), .FAULT_SLW(FS)) dut (
      .i_core_clk(clk), .i_nrst(nrst), .i_ce(1'h1), .i_watchdog_strobe(strb),
      .i_fault_clear_n(clr_n), .i_supply_in_window(win), .i_supply_over(ovr),
      .o_watchdog_fault_n(wdo_n), .o_watchdog_fault_oe(wdo_oe), .o_supply_reset_n(rst_n),
      .o_supply_reset_oe(rst_oe), .o_surge_latch_n(ov_n), .o_surge_latch_oe(ov_oe));
   // =====
   // helpers
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      num_checks++;
      if (e !== s) begin
         fails++;
         $display("Error %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   // waits up to lim cycles for a fault pulse, then measures it
   task automatic pulse(int lim, output int len);
      for (int i = 0; i < lim && wdo_n; i++) cyc(1);
      if (!wdo_n) chk("fault_oe", 1, wdo_oe);
      for (len = 0; !wdo_n && len < 300; len++) cyc(1);
   endtask
   task automatic clr_pulse(int n);
      clr_n = 0;
      cyc(n);
      clr_n = 1;
      cyc(8);
   endtask
   task automatic wait_rst(int lim);
      for (int i = 0; i < lim && !rst_n; i++) cyc(1);
   endtask
   // =====
   // tests
   task automatic t_watchdog();
      int lo = 0, len;
      go = 1;
      repeat (1500) begin
         cyc(1);
         lo += !wdo_n;
      end
      chk("fault_low_in_window", 0, lo);
      chk("fault_oe_idle", 0, wdo_oe);
      gap = 16'h000A;
      pulse(100, len);
      chk("fast_pulse_len", FF, len);
      go = 0;
      // a strobe still in the synchroniser may add one fast pulse
      pulse(40, len);
      pulse(400, len);
      chk("slow_pulse_len", FS, len);
      $display("watchdog test done");
   endtask
   task automatic t_supply();
      win = 0;
      cyc(6);
      chk("reset_low", 0, rst_n);
      chk("reset_oe", 1, rst_oe);
      win = 1;
      cyc(HD - 2);
      chk("reset_hold", 0, rst_n);
      wait_rst(12);
      chk("reset_release", 1, rst_n);
      $display("supply test done");
   endtask
   task automatic t_surge();
      ovr = 1;
      cyc(8);
      chk("surge_set", 0, ov_n);
      chk("surge_oe", 1, ov_oe);
      clr_pulse(10);
      chk("clear_while_over", 0, ov_n);
      ovr = 0;
      cyc(20);
      chk("surge_sticky", 0, ov_n);
      clr_pulse(2);
      chk("short_clear", 0, ov_n);
      clr_pulse(4);
      chk("surge_cleared", 1, ov_n);
      chk("surge_oe_off", 0, ov_oe);
      clr_pulse(70);
      chk("long_clear_reset", 0, rst_n);
      wait_rst(40);
      chk("long_clear_release", 1, rst_n);
      $display("surge test done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      cyc(5);
      nrst = 1;
      wait_rst(60);
      chk("reset_after_start", 1, rst_n);
      t_watchdog();
      t_supply();
      t_surge();
      test_done();
   end
   initial begin
      cyc(20000);
      fails++;
      test_done();
   end
endmodule
`default_nettype wire
